// File: tws_pkg.sv
// Constants, register map, status codes and state type of the two-wire slave receiver.
// Assumes a 50 MHz system clock; every user includes nothing and names tws_pkg:: directly.
package tws_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] SPIKE_LAST = 3'(SPIKE_CYC - 1);
  localparam int HALF_NS = 5000;
  localparam int HALF_CYC = HALF_NS / CLK_NS;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_OWN = 2'h3;
  localparam int CTRL_DONE = 7;
  localparam int CTRL_ACK = 6;
  localparam int CTRL_START = 5;
  localparam int CTRL_STOP = 4;
  localparam int CTRL_MTX = 3;
  localparam int CTRL_EN = 2;
  localparam int CTRL_MRX = 1;
  localparam int CTRL_IE = 0;
  localparam int STAT_CODE_LSB = 3;
  localparam int OWN_GCE_BIT = 0;
  localparam logic [7:0] OWN_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Bus constants
  // ---------------------------------------------------------------
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  localparam logic RW_WRITE = 1'b0;
  localparam logic [7:0] ALL_RELEASED = 8'hFF;

  // ---------------------------------------------------------------
  // Status codes, prescaler bits as zero
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_IDLE = 8'hF8;
  localparam logic [7:0] CODE_START_SENT = 8'h08;
  localparam logic [7:0] CODE_MTX_ADDR_ACK = 8'h18;
  localparam logic [7:0] CODE_MTX_ADDR_NACK = 8'h20;
  localparam logic [7:0] CODE_MTX_DATA_ACK = 8'h28;
  localparam logic [7:0] CODE_MTX_DATA_NACK = 8'h30;
  localparam logic [7:0] CODE_MRX_ADDR_ACK = 8'h40;
  localparam logic [7:0] CODE_MRX_ADDR_NACK = 8'h48;
  localparam logic [7:0] CODE_MRX_DATA_ACK = 8'h50;
  localparam logic [7:0] CODE_MRX_DATA_NACK = 8'h58;
  localparam logic [7:0] CODE_OWN_ADDR = 8'h60;
  localparam logic [7:0] CODE_LOST_OWN_ADDR = 8'h68;
  localparam logic [7:0] CODE_GCALL_ADDR = 8'h70;
  localparam logic [7:0] CODE_LOST_GCALL_ADDR = 8'h78;
  localparam logic [7:0] CODE_OWN_DATA_ACK = 8'h80;
  localparam logic [7:0] CODE_OWN_DATA_NACK = 8'h88;
  localparam logic [7:0] CODE_GCALL_DATA_ACK = 8'h90;
  localparam logic [7:0] CODE_GCALL_DATA_NACK = 8'h98;
  localparam logic [7:0] CODE_STOP_RESTART = 8'hA0;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RX,
    S_ACK,
    S_HOLD,
    S_M_START,
    S_M_SEND,
    S_M_STOP
  } tws_state_e;

endpackage

// File: tws_slave_rx.sv
// Two-wire serial unit: slave receiver with START, address and STOP generation as master.
// Assumes open-drain wiring outside: the bench resolves each line from the output enables.
//
// Behaviour
// - Each packet is eight data bits plus one acknowledge bit.
// - Acknowledge is data held low in the ninth clock; high means no acknowledge.
// - Receiver answers last or unwanted byte with not-acknowledge.
// - Bytes travel most significant bit first.
// - Master makes clock, START and STOP; receiver makes acknowledges.
// - Transfer is START, address, data, STOP; START then STOP is illegal.
// - Slaves may stretch clock low; master waits for the line to rise.
// - Own-address bits 7 to 1 hold the seven-bit slave address.
// - Own-address bit 0 enables general call recognition.
// - Interrupt when done flag, interrupt enable and global enable are all set.
// - When the done flag sets, the status code describes the bus state.
// - Writing one clears the done flag; no bus action while it is set.
// - A sent START sets the done flag with a START-sent code.
// - Address with write bit enters master transmit, read bit master receive.
// - Status codes assume prescaler bits zero; software masks them.
// - Own write address received and acknowledged reports 0x60.
// - After lost arbitration, own address reports 0x68, general call 0x78.
// - Own-address data bytes report 0x80 acknowledged, 0x88 not acknowledged.
// - General-call data bytes report 0x90 acknowledged, 0x98 not acknowledged.
// - STOP or repeated START while addressed reports 0xA0.
// - After clearing, next byte is acknowledged exactly when acknowledge enable is set.
// - After 0x88, 0x98, 0xA0 the unit is not addressed; START request waits free bus.
// - Enable hands the pins to the unit as filtered open-drain lines.
//
// The register addresses and the address-and-strobe port were decided locally.
module tws_slave_rx #(
  parameter int HALF_CYC = tws_pkg::HALF_CYC,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Interrupt
  input wire logic i_global_irq_en,
  output logic o_irq,
  // Bus lines
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // Pin ownership
  output logic o_link_owns_pins
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_MID = CNT_W'(HALF_CYC / 2);

  tws_pkg::tws_state_e st_reg, st_next;
  logic [3:0] bitcnt_reg, bitcnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic [CNT_W-1:0] mcnt_reg, mcnt_next;
  logic scl_low_reg, scl_low_next;
  logic sda_low_reg, sda_low_next;
  logic addressed_reg, addressed_next;
  logic gcall_reg, gcall_next;
  logic arb_lost_reg, arb_lost_next;
  logic addr_phase_reg, addr_phase_next;
  logic master_reg, master_next;
  logic mtx_reg, mtx_next;
  logic mrx_reg, mrx_next;
  logic ack_given_reg, ack_given_next;
  logic ack_bit_reg, ack_bit_next;
  logic [7:0] code_reg, code_next;
  logic set_done;
  logic data_load;
  logic stop_done;

  logic done_reg, ack_en_reg, start_req_reg, stop_req_reg, en_reg, ie_reg;
  logic [1:0] presc_reg;
  logic [7:0] data_reg, own_reg, rdata_reg;
  logic irq_reg, owns_reg, line_level_reg, busy_reg, scl_prev_reg, sda_prev_reg;
  logic [1:0] line_f;

  // ---------------------------------------------------------------
  // Pin synchronisers and spike filters
  // ---------------------------------------------------------------
  wire [1:0] pin_in = {i_sda, i_scl};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      logic [2:0] sync_reg;
      logic [2:0] cnt_reg;
      logic filt_reg;
      wire agree = sync_reg[1] == sync_reg[2];
      wire differ = agree && (sync_reg[2] != filt_reg);
      // A level must stand for the whole spike window before it is believed.
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          sync_reg <= 3'h7;
          cnt_reg <= 3'h0;
          filt_reg <= 1'b1;
        end else begin
          sync_reg <= {sync_reg[1:0], pin_in[g]};
          if (!differ) begin
            cnt_reg <= 3'h0;
          end else if (cnt_reg == tws_pkg::SPIKE_LAST) begin
            filt_reg <= sync_reg[2];
            cnt_reg <= 3'h0;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
      end
      assign line_f[g] = filt_reg;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Bus event decode
  // ---------------------------------------------------------------
  wire scl_f = line_f[0];
  wire sda_f = line_f[1];
  wire scl_rise = scl_f && !scl_prev_reg;
  wire scl_fall = !scl_f && scl_prev_reg;
  wire start_det = scl_f && scl_prev_reg && sda_prev_reg && !sda_f;
  wire stop_det = scl_f && scl_prev_reg && !sda_prev_reg && sda_f;
  wire bus_cond = start_det || stop_det;
  wire own_cond = (st_reg == tws_pkg::S_M_START) || (st_reg == tws_pkg::S_M_STOP);
  wire byte_done = bitcnt_reg == tws_pkg::LAST_BIT;
  wire rx_data = mrx_reg && !addr_phase_reg;
  wire ack_ok = !ack_bit_reg;

  wire own_match = (shift_reg[7:1] == own_reg[7:1]) && (shift_reg[0] == tws_pkg::RW_WRITE);
  wire gc_match = (shift_reg == tws_pkg::GCALL_ADDR) && own_reg[tws_pkg::OWN_GCE_BIT];
  // A new address is refused while software still owns the previous event.
  wire addr_hit = ack_en_reg && !done_reg && (own_match || gc_match);

  wire [7:0] slave_addr_code = gcall_reg ?
      (arb_lost_reg ? tws_pkg::CODE_LOST_GCALL_ADDR : tws_pkg::CODE_GCALL_ADDR) :
      (arb_lost_reg ? tws_pkg::CODE_LOST_OWN_ADDR : tws_pkg::CODE_OWN_ADDR);
  wire [7:0] slave_data_code = gcall_reg ?
      (ack_given_reg ? tws_pkg::CODE_GCALL_DATA_ACK : tws_pkg::CODE_GCALL_DATA_NACK) :
      (ack_given_reg ? tws_pkg::CODE_OWN_DATA_ACK : tws_pkg::CODE_OWN_DATA_NACK);
  wire [7:0] slave_code = addr_phase_reg ? slave_addr_code : slave_data_code;
  wire [7:0] mtx_code = addr_phase_reg ?
      (ack_ok ? tws_pkg::CODE_MTX_ADDR_ACK : tws_pkg::CODE_MTX_ADDR_NACK) :
      (ack_ok ? tws_pkg::CODE_MTX_DATA_ACK : tws_pkg::CODE_MTX_DATA_NACK);
  wire [7:0] mrx_code = addr_phase_reg ?
      (ack_ok ? tws_pkg::CODE_MRX_ADDR_ACK : tws_pkg::CODE_MRX_ADDR_NACK) :
      (ack_ok ? tws_pkg::CODE_MRX_DATA_ACK : tws_pkg::CODE_MRX_DATA_NACK);
  wire [7:0] master_code = (addr_phase_reg ? shift_reg[0] : mrx_reg) ? mrx_code : mtx_code;

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  wire wr_ctrl = i_wr && (i_addr == tws_pkg::REG_CTRL);
  wire wr_stat = i_wr && (i_addr == tws_pkg::REG_STAT);
  wire wr_data = i_wr && (i_addr == tws_pkg::REG_DATA);
  wire wr_own = i_wr && (i_addr == tws_pkg::REG_OWN);
  wire [7:0] ctrl_view = {done_reg, ack_en_reg, start_req_reg, stop_req_reg,
                          mtx_reg, en_reg, mrx_reg, ie_reg};
  wire [7:0] stat_view = {code_reg[7:tws_pkg::STAT_CODE_LSB], 1'b0, presc_reg};
  wire [7:0] rd_mux = (i_addr == tws_pkg::REG_CTRL) ? ctrl_view :
                      (i_addr == tws_pkg::REG_STAT) ? stat_view :
                      (i_addr == tws_pkg::REG_DATA) ? data_reg : own_reg;
  // The set wins over a clear written in the same cycle.
  wire done_next = set_done ? 1'b1 :
                   (wr_ctrl && i_wdata[tws_pkg::CTRL_DONE]) ? 1'b0 : done_reg;
  wire stop_req_next = wr_ctrl ? i_wdata[tws_pkg::CTRL_STOP] :
                       stop_done ? 1'b0 : stop_req_reg;
  wire [7:0] data_next = data_load ? shift_reg : wr_data ? i_wdata : data_reg;
  wire irq_next = done_reg && ie_reg && i_global_irq_en;

  // ---------------------------------------------------------------
  // Transfer state machine
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    bitcnt_next = bitcnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    mcnt_next = mcnt_reg;
    scl_low_next = scl_low_reg;
    sda_low_next = sda_low_reg;
    addressed_next = addressed_reg;
    gcall_next = gcall_reg;
    arb_lost_next = arb_lost_reg;
    addr_phase_next = addr_phase_reg;
    master_next = master_reg;
    mtx_next = mtx_reg;
    mrx_next = mrx_reg;
    ack_given_next = ack_given_reg;
    ack_bit_next = ack_bit_reg;
    code_next = code_reg;
    set_done = 1'b0;
    data_load = 1'b0;
    stop_done = 1'b0;
    if (!en_reg) begin
      st_next = tws_pkg::S_IDLE;
      scl_low_next = 1'b0;
      sda_low_next = 1'b0;
      addressed_next = 1'b0;
      master_next = 1'b0;
      mtx_next = 1'b0;
      mrx_next = 1'b0;
    end else if (bus_cond && !own_cond) begin
      if (addressed_reg) begin
        set_done = 1'b1;
        code_next = tws_pkg::CODE_STOP_RESTART;
      end
      addressed_next = 1'b0;
      master_next = 1'b0;
      mtx_next = 1'b0;
      mrx_next = 1'b0;
      arb_lost_next = 1'b0;
      scl_low_next = 1'b0;
      sda_low_next = 1'b0;
      bitcnt_next = 4'h0;
      addr_phase_next = 1'b1;
      st_next = start_det ? tws_pkg::S_RX : tws_pkg::S_IDLE;
    end else begin
      case (st_reg)
        tws_pkg::S_IDLE: begin
          if (start_req_reg && !done_reg && !busy_reg) begin
            sda_low_next = 1'b1;
            mcnt_next = '0;
            st_next = tws_pkg::S_M_START;
          end
        end
        tws_pkg::S_RX: begin
          if (scl_rise && !byte_done) begin
            shift_next = {shift_reg[6:0], sda_f};
            bitcnt_next = bitcnt_reg + 4'h1;
          end else if (scl_fall && byte_done) begin
            if (!addr_phase_reg) begin
              ack_given_next = ack_en_reg;
              sda_low_next = ack_en_reg;
              st_next = tws_pkg::S_ACK;
            end else if (addr_hit) begin
              ack_given_next = 1'b1;
              sda_low_next = 1'b1;
              addressed_next = 1'b1;
              gcall_next = gc_match && !own_match;
              st_next = tws_pkg::S_ACK;
            end else begin
              st_next = tws_pkg::S_IDLE;
            end
          end
        end
        tws_pkg::S_ACK: begin
          if (scl_fall) begin
            sda_low_next = 1'b0;
            scl_low_next = 1'b1;
            set_done = 1'b1;
            code_next = slave_code;
            data_load = !addr_phase_reg;
            addr_phase_next = 1'b0;
            if (!addr_phase_reg && !ack_given_reg) begin
              addressed_next = 1'b0;
            end
            st_next = tws_pkg::S_HOLD;
          end
        end
        tws_pkg::S_HOLD: begin
          if (!done_reg) begin
            bitcnt_next = 4'h0;
            mcnt_next = '0;
            if (!master_reg) begin
              scl_low_next = 1'b0;
              st_next = addressed_reg ? tws_pkg::S_RX : tws_pkg::S_IDLE;
            end else if (stop_req_reg && !addr_phase_reg) begin
              sda_low_next = 1'b1;
              st_next = tws_pkg::S_M_STOP;
            end else begin
              tx_next = rx_data ? tws_pkg::ALL_RELEASED : data_reg;
              st_next = tws_pkg::S_M_SEND;
            end
          end
        end
        tws_pkg::S_M_START: begin
          mcnt_next = mcnt_reg + 1'b1;
          if (mcnt_reg == HALF_LAST) begin
            scl_low_next = 1'b1;
            master_next = 1'b1;
            set_done = 1'b1;
            code_next = tws_pkg::CODE_START_SENT;
            addr_phase_next = 1'b1;
            arb_lost_next = 1'b0;
            st_next = tws_pkg::S_HOLD;
          end
        end
        tws_pkg::S_M_SEND: begin
          if (scl_low_reg) begin
            mcnt_next = mcnt_reg + 1'b1;
            // Data moves mid-way through the low phase, never beside a clock edge.
            if (mcnt_reg == HALF_MID) begin
              sda_low_next = byte_done ? (rx_data && ack_en_reg) : !tx_reg[7];
            end
            if (mcnt_reg == HALF_LAST) begin
              scl_low_next = 1'b0;
              mcnt_next = '0;
            end
          end else if (scl_f) begin
            mcnt_next = mcnt_reg + 1'b1;
            if (scl_rise && !byte_done) begin
              shift_next = {shift_reg[6:0], sda_f};
              if (tx_reg[7] && !sda_f && !rx_data) begin
                master_next = 1'b0;
                mtx_next = 1'b0;
                mrx_next = 1'b0;
                arb_lost_next = addr_phase_reg;
                sda_low_next = 1'b0;
                bitcnt_next = bitcnt_reg + 4'h1;
                st_next = tws_pkg::S_RX;
              end
            end
            if (scl_rise && byte_done) begin
              ack_bit_next = sda_f;
            end
            if (mcnt_reg == HALF_LAST) begin
              scl_low_next = 1'b1;
              mcnt_next = '0;
              tx_next = {tx_reg[6:0], 1'b1};
              if (byte_done) begin
                set_done = 1'b1;
                code_next = master_code;
                data_load = rx_data;
                if (addr_phase_reg) begin
                  mtx_next = shift_reg[0] == tws_pkg::RW_WRITE;
                  mrx_next = shift_reg[0] != tws_pkg::RW_WRITE;
                end
                addr_phase_next = 1'b0;
                st_next = tws_pkg::S_HOLD;
              end else begin
                bitcnt_next = bitcnt_reg + 4'h1;
              end
            end
          end
        end
        tws_pkg::S_M_STOP: begin
          if (scl_low_reg) begin
            mcnt_next = mcnt_reg + 1'b1;
            if (mcnt_reg == HALF_LAST) begin
              scl_low_next = 1'b0;
              mcnt_next = '0;
            end
          end else if (scl_f) begin
            mcnt_next = mcnt_reg + 1'b1;
            if (mcnt_reg == HALF_LAST) begin
              sda_low_next = 1'b0;
              stop_done = 1'b1;
              master_next = 1'b0;
              mtx_next = 1'b0;
              mrx_next = 1'b0;
              st_next = tws_pkg::S_IDLE;
            end
          end
        end
        default: begin
          st_next = tws_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= tws_pkg::S_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      mcnt_reg <= '0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      addressed_reg <= 1'b0;
      gcall_reg <= 1'b0;
      arb_lost_reg <= 1'b0;
      addr_phase_reg <= 1'b1;
      master_reg <= 1'b0;
      mtx_reg <= 1'b0;
      mrx_reg <= 1'b0;
      ack_given_reg <= 1'b0;
      ack_bit_reg <= 1'b1;
      code_reg <= tws_pkg::CODE_IDLE;
    end else begin
      st_reg <= st_next;
      bitcnt_reg <= bitcnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      mcnt_reg <= mcnt_next;
      scl_low_reg <= scl_low_next;
      sda_low_reg <= sda_low_next;
      addressed_reg <= addressed_next;
      gcall_reg <= gcall_next;
      arb_lost_reg <= arb_lost_next;
      addr_phase_reg <= addr_phase_next;
      master_reg <= master_next;
      mtx_reg <= mtx_next;
      mrx_reg <= mrx_next;
      ack_given_reg <= ack_given_next;
      ack_bit_reg <= ack_bit_next;
      code_reg <= code_next;
    end
  end

  // ---------------------------------------------------------------
  // Software registers and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      done_reg <= 1'b0;
      {ack_en_reg, start_req_reg, en_reg, ie_reg} <= 4'h0;
      stop_req_reg <= 1'b0;
      presc_reg <= 2'h0;
      data_reg <= tws_pkg::DATA_RESET;
      own_reg <= tws_pkg::OWN_RESET;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      owns_reg <= 1'b0;
      line_level_reg <= 1'b0;
      busy_reg <= 1'b0;
      {scl_prev_reg, sda_prev_reg} <= 2'h3;
    end else begin
      done_reg <= done_next;
      if (wr_ctrl) begin
        ack_en_reg <= i_wdata[tws_pkg::CTRL_ACK];
        start_req_reg <= i_wdata[tws_pkg::CTRL_START];
        en_reg <= i_wdata[tws_pkg::CTRL_EN];
        ie_reg <= i_wdata[tws_pkg::CTRL_IE];
      end
      stop_req_reg <= stop_req_next;
      if (wr_stat) begin
        presc_reg <= i_wdata[1:0];
      end
      data_reg <= data_next;
      if (wr_own) begin
        own_reg <= i_wdata;
      end
      rdata_reg <= i_rd ? rd_mux : 8'h00;
      irq_reg <= irq_next;
      owns_reg <= en_reg;
      line_level_reg <= 1'b0;
      busy_reg <= en_reg && (start_det || (busy_reg && !stop_det));
      {scl_prev_reg, sda_prev_reg} <= {scl_f, sda_f};
    end
  end

  assign o_rdata = rdata_reg;
  assign o_irq = irq_reg;
  assign o_scl = line_level_reg;
  assign o_sda = line_level_reg;
  assign o_scl_oe = scl_low_reg;
  assign o_sda_oe = sda_low_reg;
  assign o_link_owns_pins = owns_reg;

endmodule // tws_slave_rx

// File: tws_slave_rx_assertions.sv
// Port checker for the two-wire slave receiver.
// Assumes a bind from the bench onto every port of the design.
module tws_slave_rx_assertions (
  input wire logic i_ref_clk, i_rst, i_wr, i_rd, i_global_irq_en, i_scl, i_sda,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata, o_rdata,
  input wire logic o_irq, o_scl, o_scl_oe, o_sda, o_sda_oe, o_link_owns_pins
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic cw;
  logic mst;
  assign cw = i_wr && i_addr == tws_pkg::REG_CTRL;
  // Master phases move the lines while the clock is high, so line timing checks stop for good at the first START request.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) mst <= 1'b0;
    else if (cw && i_wdata[tws_pkg::CTRL_START]) mst <= 1'b1;
  end
  od_zero_a: assert property (!o_scl && !o_sda) else $error("line driven high");
  pins_on_a: assert property ($rose(o_link_owns_pins) |->
    $past(cw && i_wdata[tws_pkg::CTRL_EN], 2)) else $error("pins taken unasked");
  pins_off_a: assert property ($fell(o_link_owns_pins) |->
    $past(cw && !i_wdata[tws_pkg::CTRL_EN], 2)) else $error("pins lost unasked");
  off_quiet_a: assert property (!o_link_owns_pins && !$past(o_link_owns_pins) |->
    !o_scl_oe && !o_sda_oe) else $error("line driven while disabled");
  irq_gate_a: assert property (o_irq |-> $past(i_global_irq_en)) else $error("irq ungated");
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata idle");
  ack_low_a: assert property (!mst && $changed(o_sda_oe) |-> !i_scl)
    else $error("data moved with clock high");
  stretch_a: assert property (!mst && $rose(o_scl_oe) |-> !i_scl)
    else $error("clock pulled while high");
  release_a: assert property (!mst && o_scl_oe && cw && i_wdata[tws_pkg::CTRL_DONE]
    |-> ##[1:3] !o_scl_oe) else $error("clock not released");
endmodule // tws_slave_rx_assertions

// File: tws_bus_master.sv
// Behavioural bus master facing the slave receiver.
// Assumes each line is a pull-up wired AND of all drivers.
module tws_bus_master (
  input wire logic i_scl, i_sda,
  output logic o_scl_low, o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 160;
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // The high phase starts only once the wired line rises, so stretching holds us off.
  task automatic bit_io(input logic b, output logic s);
    #Q o_sda_low = ~b;
    #Q o_scl_low = 1'b0;
    wait (i_scl);
    #(2*Q) s = i_sda;
    o_scl_low = 1'b1;
  endtask
  task automatic start();
    o_sda_low = 1'b1;
    #(2*Q) o_scl_low = 1'b1;
  endtask
  task automatic stop();
    #Q o_sda_low = 1'b1;
    #Q o_scl_low = 1'b0;
    wait (i_scl);
    #(2*Q) o_sda_low = 1'b0;
    #(4*Q);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask
endmodule // tws_bus_master

// File: tws_slave_rx_test.sv
// Bench for the two-wire slave receiver: register tasks against a modelled bus master.
// Assumes package, design, checker and master model are compiled first.
module tws_slave_rx_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, gie = 1'b1;
  logic m_scl, m_sda, scl, sda, scl_oe, sda_oe, scl_o, sda_o, owns, irq;
  logic [1:0] addr = 2'h0;
  logic [7:0] wd = 8'h00, rdat, d;
  int err_count = 0, cmp_count = 0;
  localparam logic [7:0] C_NAK = 8'(2**tws_pkg::CTRL_DONE + 2**tws_pkg::CTRL_EN + 1);
  localparam logic [7:0] C_ACK = C_NAK | 8'(2**tws_pkg::CTRL_ACK);
  always #10 clk = ~clk;
  assign scl = (scl_oe ? scl_o : 1'b1) & ~m_scl;
  assign sda = (sda_oe ? sda_o : 1'b1) & ~m_sda;
  tws_slave_rx DUT (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdat), .i_global_irq_en(gie), .o_irq(irq), .i_scl(scl), .o_scl(scl_o),
    .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe), .o_link_owns_pins(owns));
  tws_bus_master M (.i_scl(scl), .i_sda(sda), .o_scl_low(m_scl), .o_sda_low(m_sda));
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk) {addr, wd, wr} <= {a, v, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 v = rdat;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A code of zero means the flag must stay clear; slave data codes 0x80 to 0x98 also carry byte b.
  task automatic done(input logic [7:0] code, input logic [7:0] ctl, input logic [7:0] b);
    logic [7:0] v;
    v = 8'h00;
    for (int n = 0; n < 200 && v[7] !== 1'b1; n++) rd_reg(tws_pkg::REG_CTRL, v);
    chk("done", {code != 8'h00, 7'h00}, v & 8'h80);
    if (code != 8'h00) begin
      chk("irq", {7'h00, gie}, {7'h00, irq});
      rd_reg(tws_pkg::REG_STAT, v);
      chk("code", code, v & 8'hF8);
      rd_reg(tws_pkg::REG_DATA, v);
      if (code[7] && !code[5]) chk("data", b, v);
      wr_reg(tws_pkg::REG_CTRL, ctl);
    end
  endtask
  task automatic xfer(input logic [7:0] b, input logic ea, input logic [7:0] code,
    input logic [7:0] ctl);
    logic a;
    M.send(b, a);
    chk("ack", {7'h00, ea}, {7'h00, a});
    done(code, ctl, b);
  endtask
  initial begin
    #1_000_000;
    err_count++;
    $display("Error watchdog expected done seen hang");
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(tws_pkg::REG_STAT, d);
    chk("stat", tws_pkg::CODE_IDLE, d);
    rd_reg(tws_pkg::REG_OWN, d);
    chk("own", tws_pkg::OWN_RESET, d);
    wr_reg(tws_pkg::REG_OWN, 8'h55);
    wr_reg(tws_pkg::REG_CTRL, C_ACK);
    rd_reg(tws_pkg::REG_OWN, d);
    chk("own", 8'h55, d);
    chk("owns", 8'h01, {7'h00, owns});
    M.start();
    xfer(8'h54, 1'b0, tws_pkg::CODE_OWN_ADDR, C_ACK);
    xfer(8'hA5, 1'b0, tws_pkg::CODE_OWN_DATA_ACK, C_NAK);
    xfer(8'h3C, 1'b1, tws_pkg::CODE_OWN_DATA_NACK, C_ACK);
    M.stop();
    $display("test own address done");
    M.start();
    xfer(8'h00, 1'b0, tws_pkg::CODE_GCALL_ADDR, C_ACK);
    xfer(8'h11, 1'b0, tws_pkg::CODE_GCALL_DATA_ACK, C_NAK);
    xfer(8'h22, 1'b1, tws_pkg::CODE_GCALL_DATA_NACK, C_ACK);
    M.stop();
    $display("test general call done");
    @(posedge clk) gie <= 1'b0;
    M.start();
    xfer(8'h54, 1'b0, tws_pkg::CODE_OWN_ADDR, C_ACK);
    M.stop();
    done(tws_pkg::CODE_STOP_RESTART, C_NAK, 8'h00);
    @(posedge clk) gie <= 1'b1;
    M.start();
    xfer(8'h54, 1'b1, 8'h00, C_NAK);
    M.stop();
    wr_reg(tws_pkg::REG_OWN, 8'h54);
    wr_reg(tws_pkg::REG_CTRL, C_ACK);
    M.start();
    xfer(8'h00, 1'b1, 8'h00, C_ACK);
    M.stop();
    M.start();
    xfer(8'h20, 1'b1, 8'h00, C_ACK);
    M.stop();
    wr_reg(tws_pkg::REG_CTRL, C_NAK | 8'h20);
    done(tws_pkg::CODE_START_SENT, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    chk("owns", 8'h00, {7'h00, owns});
    $display("test refusals done");
    conclude();
  end
endmodule // tws_slave_rx_test
bind tws_slave_rx tws_slave_rx_assertions CHK (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wr(i_wr),
  .i_rd(i_rd), .i_global_irq_en(i_global_irq_en), .i_scl(i_scl), .i_sda(i_sda), .i_addr(i_addr),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq(o_irq), .o_scl(o_scl), .o_scl_oe(o_scl_oe),
  .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_link_owns_pins(o_link_owns_pins));
